// File: src/ipbc_pkg.sv
// Summary of operation
// - Sixteen groups of two address qualifiers are provided and their matches are ORed together.
// - With the global condition on, no group matches unless the selected level 1 to 4 is true.
// - One enable bit turns the global level condition on or off.
// - Each of the two qualifiers has its own enable and a disabled one never matches.
// - Range mode matches when first qualifier <= IP < second qualifier.
// - A matching range group with trigger selected raises the trace stop signal.
// - A range group with record selected enables recording only while it matches.
// - User-on drives the user output line high and it stays high until cleared.
// - User-off clears the user output line low.
// - A matching range group with break selected halts emulation.
// - Equality mode compares each qualifier alone and an exact match starts its actions.
// - Equality mode can record the matching cycles per qualifier.
// - Equality mode can stop emulation on a match per qualifier.
// - Breaks act without skid, the matched instruction is not executed.
// - Groups match only in advanced trace mode.
// - Only instruction pointer values take part in group matches.
package ipbc_pkg;
  localparam int IPBC_IP_W = 24;
  localparam int IPBC_NGRP = 16;
  localparam int IPBC_NLVL = 4;
  localparam int IPBC_AW = 12;
  localparam int IPBC_CFG_W = 12;
  localparam int IPBC_CTRL_W = 4;
  localparam int IPBC_IRQ_W = 3;
  typedef logic [IPBC_IP_W-1:0] ipbc_ip_t;
  typedef logic [IPBC_CFG_W-1:0] ipbc_cfg_t;
  typedef logic [IPBC_AW-1:0] ipbc_addr_t;
  // Register offsets
  localparam ipbc_addr_t IPBC_OFF_CTRL = 12'h000;
  localparam ipbc_addr_t IPBC_OFF_STATUS = 12'h004;
  localparam ipbc_addr_t IPBC_OFF_IRQ_CLR = 12'h008;
  localparam ipbc_addr_t IPBC_OFF_IRQ_EN = 12'h00c;
  localparam ipbc_addr_t IPBC_OFF_STATE = 12'h010;
  localparam ipbc_addr_t IPBC_OFF_CMD = 12'h014;
  localparam logic [3:0] IPBC_GRP_PAGE = 4'h1;
  localparam logic [1:0] IPBC_FLD_FIRST = 2'h0;
  localparam logic [1:0] IPBC_FLD_SECOND = 2'h1;
  localparam logic [1:0] IPBC_FLD_CFG = 2'h2;
  // Control fields
  localparam int IPBC_CTRL_ADV = 0;
  localparam int IPBC_CTRL_GLOB = 1;
  localparam int IPBC_CTRL_LVL = 2;
  localparam logic [IPBC_CTRL_W-1:0] IPBC_CTRL_RST = 4'h0;
  // Group configuration fields
  localparam int IPBC_CFG_EN_FIRST = 0;
  localparam int IPBC_CFG_EN_SECOND = 1;
  localparam int IPBC_CFG_RANGE = 2;
  localparam int IPBC_CFG_TRIG = 3;
  localparam int IPBC_CFG_REC = 4;
  localparam int IPBC_CFG_USER_ON = 5;
  localparam int IPBC_CFG_USER_OFF = 6;
  localparam int IPBC_CFG_BRK = 7;
  localparam int IPBC_CFG_REC_FIRST = 8;
  localparam int IPBC_CFG_REC_SECOND = 9;
  localparam int IPBC_CFG_BRK_FIRST = 10;
  localparam int IPBC_CFG_BRK_SECOND = 11;
  // Status, state and command fields
  localparam int IPBC_ST_TRIG = 0;
  localparam int IPBC_ST_BRK = 1;
  localparam int IPBC_ST_USER = 2;
  localparam int IPBC_STATE_USER = 0;
  localparam int IPBC_STATE_HALT = 1;
  localparam int IPBC_CMD_RESUME = 0;
  localparam int IPBC_CMD_USER_CLR = 1;
  localparam logic [1:0] IPBC_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPBC_RESP_SLVERR = 2'h2;
endpackage : ipbc_pkg

// File: src/ipbc_grp_if.sv
`timescale 1ns/1ps
interface ipbc_grp_if;
  import ipbc_pkg::*;
  ipbc_ip_t ip;
  ipbc_ip_t first;
  ipbc_ip_t second;
  ipbc_cfg_t cfg;
  logic qual_ok;
  logic range_hit;
  logic eq_first;
  logic eq_second;
  logic hit;
  logic trig;
  logic rec;
  logic uon;
  logic uoff;
  logic brk;
  modport cmp (
    input ip, first, second, cfg, qual_ok,
    output range_hit, eq_first, eq_second, hit, trig, rec, uon, uoff, brk
  );
  modport ctl (
    output ip, first, second, cfg, qual_ok,
    input range_hit, eq_first, eq_second, hit, trig, rec, uon, uoff, brk
  );
endinterface : ipbc_grp_if

// File: src/ipbc_group.sv
`timescale 1ns/1ps
module ipbc_group
  import ipbc_pkg::*;
(
  // Clock and reset for checks
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Group compare link
  ipbc_grp_if.cmp g
);
  logic en1;
  logic en2;
  logic rng;
  assign en1 = g.cfg[IPBC_CFG_EN_FIRST];
  assign en2 = g.cfg[IPBC_CFG_EN_SECOND];
  assign rng = g.cfg[IPBC_CFG_RANGE];
  // Only IP enters the comparators
  assign g.range_hit = g.qual_ok & rng & en1 & en2 & (g.ip >= g.first) & (g.ip < g.second);
  assign g.eq_first = g.qual_ok & ~rng & en1 & (g.ip == g.first);
  assign g.eq_second = g.qual_ok & ~rng & en2 & (g.ip == g.second);
  assign g.hit = g.range_hit | g.eq_first | g.eq_second;
  assign g.trig = g.hit & g.cfg[IPBC_CFG_TRIG];
  assign g.rec = (g.range_hit & g.cfg[IPBC_CFG_REC])
    | (g.eq_first & g.cfg[IPBC_CFG_REC_FIRST])
    | (g.eq_second & g.cfg[IPBC_CFG_REC_SECOND]);
  assign g.uon = g.hit & g.cfg[IPBC_CFG_USER_ON];
  assign g.uoff = g.hit & g.cfg[IPBC_CFG_USER_OFF];
  assign g.brk = (g.range_hit & g.cfg[IPBC_CFG_BRK])
    | (g.eq_first & g.cfg[IPBC_CFG_BRK_FIRST])
    | (g.eq_second & g.cfg[IPBC_CFG_BRK_SECOND]);

  a_range_bounds: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    g.range_hit |-> (g.ip >= g.first && g.ip < g.second && rng))
    else $error("range hit outside window");
  a_qual_enable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!en1 |-> !g.eq_first && !g.range_hit) and (!en2 |-> !g.eq_second))
    else $error("disabled qualifier matched");
  a_eq_exact: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (g.qual_ok && !rng && en2 && g.ip == g.second) |-> g.eq_second && g.hit)
    else $error("exact match missed");
  a_eq_record: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (g.eq_first && g.cfg[IPBC_CFG_REC_FIRST]) |-> g.rec)
    else $error("equality record missing");
  a_eq_break: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (g.eq_second && g.cfg[IPBC_CFG_BRK_SECOND]) |-> g.brk)
    else $error("equality break missing");
endmodule : ipbc_group

// File: src/ipbc_top.sv
`timescale 1ns/1ps
module ipbc_top
  import ipbc_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Target core
  input wire logic [IPBC_IP_W-1:0] ip_i,
  input wire logic ip_valid_i,
  input wire logic [IPBC_NLVL-1:0] level_true_i,
  // Trace and emulation control
  output logic trace_stop_o,
  output logic trace_record_o,
  output logic user_output_connector_o,
  output logic halt_o,
  output logic irq_o,
  // AXI4-Lite write
  input wire logic [IPBC_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [IPBC_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  function automatic logic [31:0] ipbc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : ipbc_merge

  function automatic logic ipbc_is_grp(input ipbc_addr_t a);
    return (a[11:8] == IPBC_GRP_PAGE) && (a[3:2] != 2'h3);
  endfunction : ipbc_is_grp

  function automatic logic ipbc_mapped(input ipbc_addr_t a);
    return ipbc_is_grp(a) || a == IPBC_OFF_CTRL || a == IPBC_OFF_STATUS
      || a == IPBC_OFF_IRQ_CLR || a == IPBC_OFF_IRQ_EN || a == IPBC_OFF_STATE
      || a == IPBC_OFF_CMD;
  endfunction : ipbc_mapped

  ipbc_ip_t first_q [IPBC_NGRP];
  ipbc_ip_t second_q [IPBC_NGRP];
  ipbc_cfg_t cfg_q [IPBC_NGRP];
  logic [IPBC_CTRL_W-1:0] ctrl_q;
  logic [IPBC_IRQ_W-1:0] status_q;
  logic [IPBC_IRQ_W-1:0] irq_en_q;
  logic [IPBC_IRQ_W-1:0] irq_set;
  logic [IPBC_IRQ_W-1:0] irq_clr;
  logic halted_q;
  logic user_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic wr_fire;
  logic rd_fire;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [IPBC_NGRP-1:0] hit_v;
  logic [IPBC_NGRP-1:0] trig_v;
  logic [IPBC_NGRP-1:0] rec_v;
  logic [IPBC_NGRP-1:0] uon_v;
  logic [IPBC_NGRP-1:0] uoff_v;
  logic [IPBC_NGRP-1:0] brk_v;
  logic qual_ok;
  logic glob_en;
  logic [1:0] lvl_sel;
  logic resume_cmd;
  logic user_clr_cmd;

  // Bus handshakes
  assign s_axi_awready_o = ce_i & ~bvalid_q & s_axi_wvalid_i;
  assign s_axi_wready_o = ce_i & ~bvalid_q & s_axi_awvalid_i;
  assign s_axi_arready_o = ce_i & ~rvalid_q;
  assign wr_fire = s_axi_awvalid_i & s_axi_awready_o;
  assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;
  assign wr_idx = s_axi_awaddr_i[7:4];
  assign rd_idx = s_axi_araddr_i[7:4];
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= IPBC_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= ipbc_mapped(s_axi_awaddr_i) ? IPBC_RESP_OKAY : IPBC_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= IPBC_RESP_OKAY;
      rdata_q <= 32'h0;
    end
    else if (ce_i)
    begin
      if (rd_fire)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= ipbc_mapped(s_axi_araddr_i) ? IPBC_RESP_OKAY : IPBC_RESP_SLVERR;
        rdata_q <= rd_d;
      end
      else if (s_axi_rready_i)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Read data select, write-only words read zero
  always_comb
  begin
    rd_d = 32'h0;
    if (ipbc_is_grp(s_axi_araddr_i))
    begin
      unique case (s_axi_araddr_i[3:2])
        IPBC_FLD_FIRST: rd_d = 32'(first_q[rd_idx]);
        IPBC_FLD_SECOND: rd_d = 32'(second_q[rd_idx]);
        IPBC_FLD_CFG: rd_d = 32'(cfg_q[rd_idx]);
        default: rd_d = 32'h0;
      endcase
    end
    else
    begin
      case (s_axi_araddr_i)
        IPBC_OFF_CTRL: rd_d = 32'(ctrl_q);
        IPBC_OFF_STATUS: rd_d = 32'(status_q);
        IPBC_OFF_IRQ_EN: rd_d = 32'(irq_en_q);
        IPBC_OFF_STATE: rd_d = 32'({halted_q, user_q});
        default: rd_d = 32'h0;
      endcase
    end
  end

  // Qualifier storage, held until software rewrites it
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < IPBC_NGRP; i++)
      begin
        first_q[i] <= '0;
        second_q[i] <= '0;
        cfg_q[i] <= '0;
      end
    end
    else if (ce_i && wr_fire && ipbc_is_grp(s_axi_awaddr_i))
    begin
      unique case (s_axi_awaddr_i[3:2])
        IPBC_FLD_FIRST: first_q[wr_idx] <= ipbc_ip_t'(ipbc_merge(32'(first_q[wr_idx]),
                                                         s_axi_wdata_i, s_axi_wstrb_i));
        IPBC_FLD_SECOND: second_q[wr_idx] <= ipbc_ip_t'(ipbc_merge(32'(second_q[wr_idx]),
                                                           s_axi_wdata_i, s_axi_wstrb_i));
        IPBC_FLD_CFG: cfg_q[wr_idx] <= ipbc_cfg_t'(ipbc_merge(32'(cfg_q[wr_idx]),
                                                     s_axi_wdata_i, s_axi_wstrb_i));
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= IPBC_CTRL_RST;
      irq_en_q <= '0;
    end
    else if (ce_i && wr_fire)
    begin
      if (s_axi_awaddr_i == IPBC_OFF_CTRL)
      begin
        ctrl_q <= IPBC_CTRL_W'(ipbc_merge(32'(ctrl_q), s_axi_wdata_i, s_axi_wstrb_i));
      end
      if (s_axi_awaddr_i == IPBC_OFF_IRQ_EN)
      begin
        irq_en_q <= IPBC_IRQ_W'(ipbc_merge(32'(irq_en_q), s_axi_wdata_i, s_axi_wstrb_i));
      end
    end
  end

  assign resume_cmd = wr_fire && s_axi_awaddr_i == IPBC_OFF_CMD && s_axi_wstrb_i[0]
                      && s_axi_wdata_i[IPBC_CMD_RESUME];
  assign user_clr_cmd = wr_fire && s_axi_awaddr_i == IPBC_OFF_CMD && s_axi_wstrb_i[0]
                        && s_axi_wdata_i[IPBC_CMD_USER_CLR];
  assign irq_clr = (wr_fire && s_axi_awaddr_i == IPBC_OFF_IRQ_CLR && s_axi_wstrb_i[0])
                   ? s_axi_wdata_i[IPBC_IRQ_W-1:0] : '0;

  // Group qualification
  assign glob_en = ctrl_q[IPBC_CTRL_GLOB];
  assign lvl_sel = ctrl_q[IPBC_CTRL_LVL +: 2];
  assign qual_ok = ctrl_q[IPBC_CTRL_ADV] & ip_valid_i
                   & (~glob_en | level_true_i[lvl_sel]);

  for (genvar gi = 0; gi < IPBC_NGRP; gi++)
  begin : g_grp
    ipbc_grp_if gif ();
    assign gif.ip = ip_i;
    assign gif.first = first_q[gi];
    assign gif.second = second_q[gi];
    assign gif.cfg = cfg_q[gi];
    assign gif.qual_ok = qual_ok;
    assign hit_v[gi] = gif.hit;
    assign trig_v[gi] = gif.trig;
    assign rec_v[gi] = gif.rec;
    assign uon_v[gi] = gif.uon;
    assign uoff_v[gi] = gif.uoff;
    assign brk_v[gi] = gif.brk;
    ipbc_group u_grp (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .g(gif.cmp)
    );
  end

  // Group results ORed, stop, record and break in the same cycle as the IP
  assign trace_stop_o = |trig_v;
  assign trace_record_o = |rec_v;
  assign halt_o = halted_q | (|brk_v);
  assign user_output_connector_o = user_q;
  assign irq_o = |(status_q & irq_en_q);
  assign irq_set = {|uon_v, |brk_v, |trig_v};

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      halted_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (|brk_v)
      begin
        halted_q <= 1'b1;
      end
      else if (resume_cmd)
      begin
        halted_q <= 1'b0;
      end
    end
  end

  // Setting the line beats any clear
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      user_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (|uon_v)
      begin
        user_q <= 1'b1;
      end
      else if ((|uoff_v) || user_clr_cmd)
      begin
        user_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      status_q <= '0;
    end
    else if (ce_i)
    begin
      status_q <= (status_q & ~irq_clr) | irq_set;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_level_gate: assert property (glob_en && !level_true_i[lvl_sel] |-> hit_v == '0)
    else $error("group matched with level false");
  a_level_free: assert property (ctrl_q[IPBC_CTRL_ADV] && ip_valid_i && !glob_en |-> qual_ok)
    else $error("level gated while condition off");
  a_mode_gate: assert property (!ctrl_q[IPBC_CTRL_ADV] |-> hit_v == '0 && !trace_stop_o)
    else $error("group matched outside advanced mode");
  a_break_noskid: assert property ((|brk_v) |-> halt_o)
    else $error("break not seen in its own cycle");
  a_break_hold: assert property ((|brk_v) && ce_i ##1 !resume_cmd |=> halt_o)
    else $error("halt dropped without resume");
  a_user_set: assert property ((|uon_v) && ce_i |=> user_output_connector_o)
    else $error("user line not set");
  a_user_clear: assert property ((|uoff_v) && !(|uon_v) && ce_i |=> !user_output_connector_o)
    else $error("user line not cleared");
  a_cfg_hold: assert property (!(wr_fire && ipbc_is_grp(s_axi_awaddr_i)) |=> $stable(cfg_q[0]))
    else $error("group setup changed without write");
endmodule : ipbc_top

// File: test/ipbc_core_model.sv
`timescale 1ns/1ps
module ipbc_core_model
  import ipbc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Bench steering
  input wire logic run_i,
  input wire logic jump_i,
  input wire logic [IPBC_IP_W-1:0] target_i,
  // Breakpoint unit side
  input wire logic halt_i,
  output logic [IPBC_IP_W-1:0] ip_o,
  output logic ip_valid_o
);
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      ip_o <= '0;
      ip_valid_o <= 1'b0;
    end
    else if (halt_i || !run_i)
    begin
      // Stalled decode: matched instruction never retires, bus shows junk
      ip_valid_o <= 1'b0;
      ip_o <= ~ip_o;
    end
    else if (jump_i)
    begin
      ip_o <= target_i;
      ip_valid_o <= 1'b1;
    end
    else
    begin
      ip_o <= ip_o + 24'h2;
      ip_valid_o <= 1'b1;
    end
  end
endmodule : ipbc_core_model

// File: test/test_ipbc_top.sv
`timescale 1ns/1ps
`define CMP(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t got %h expected %h", $time, got, exp); end end
module test_ipbc_top
  import ipbc_pkg::*;
;
  logic ref_clk_i = 0;
  logic reset_i = 1;
  logic ce = 1;
  logic [IPBC_AW-1:0] awaddr = '0;
  logic [IPBC_AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic arvalid = 0;
  logic run = 0;
  logic jump = 0;
  logic [IPBC_IP_W-1:0] target = '0;
  logic [3:0] level = '0;
  logic [IPBC_IP_W-1:0] ip;
  logic ipv, stop, rec, usr, halt, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h30e497b1;
  // Reference state
  logic [3:0] ctrl;
  logic [2:0] ien, st;
  logic usr_q, hlt_q;
  logic [11:0] cfg [16];
  logic [23:0] fa [16];
  logic [23:0] sa [16];
  logic e_stop, e_rec, e_uon, e_uoff, e_brk;
  wire wt = awvalid && wvalid && awready && wready;

  always #12.5 ref_clk_i = ~ref_clk_i;

  ipbc_top uut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce),
    .ip_i(ip), .ip_valid_i(ipv), .level_true_i(level),
    .trace_stop_o(stop), .trace_record_o(rec), .user_output_connector_o(usr),
    .halt_o(halt), .irq_o(irq),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1)
  );

  ipbc_core_model core (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .run_i(run), .jump_i(jump),
    .target_i(target), .halt_i(halt), .ip_o(ip), .ip_valid_o(ipv)
  );

  always_comb
  begin
    logic q, h1, h2, hr, hh;
    {h1, h2, hr, hh} = 4'h0;
    q = ctrl[0] && ipv && (!ctrl[1] || level[ctrl[3:2]]);
    {e_stop, e_rec, e_uon, e_uoff, e_brk} = '0;
    for (int g = 0; g < IPBC_NGRP; g++)
    begin
      h1 = q && cfg[g][0] && ip == fa[g];
      h2 = q && cfg[g][1] && ip == sa[g];
      hr = q && cfg[g][0] && cfg[g][1] && ip >= fa[g] && ip < sa[g];
      hh = cfg[g][2] ? hr : (h1 || h2);
      e_stop |= hh && cfg[g][3];
      e_uon |= hh && cfg[g][5];
      e_uoff |= hh && cfg[g][6];
      e_rec |= cfg[g][2] ? hr && cfg[g][4] : (h1 && cfg[g][8]) || (h2 && cfg[g][9]);
      e_brk |= cfg[g][2] ? hr && cfg[g][7] : (h1 && cfg[g][10]) || (h2 && cfg[g][11]);
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      {ctrl, ien, st, usr_q, hlt_q} <= '0;
      for (int g = 0; g < IPBC_NGRP; g++)
      begin
        cfg[g] <= '0;
        fa[g] <= '0;
        sa[g] <= '0;
      end
    end
    else if (ce)
    begin
      st <= (st & ~(wt && awaddr == IPBC_OFF_IRQ_CLR ? wdata[2:0] : 3'h0))
        | {e_uon, e_brk, e_stop};
      hlt_q <= e_brk || (hlt_q && !(wt && awaddr == IPBC_OFF_CMD && wdata[0]));
      usr_q <= e_uon || (usr_q && !e_uoff && !(wt && awaddr == IPBC_OFF_CMD && wdata[1]));
      if (wt && awaddr == IPBC_OFF_CTRL) ctrl <= wdata[3:0];
      if (wt && awaddr == IPBC_OFF_IRQ_EN) ien <= wdata[2:0];
      if (wt && awaddr[11:8] == IPBC_GRP_PAGE && awaddr[3:2] == IPBC_FLD_FIRST)
        fa[awaddr[7:4]] <= wdata[23:0];
      if (wt && awaddr[11:8] == IPBC_GRP_PAGE && awaddr[3:2] == IPBC_FLD_SECOND)
        sa[awaddr[7:4]] <= wdata[23:0];
      if (wt && awaddr[11:8] == IPBC_GRP_PAGE && awaddr[3:2] == IPBC_FLD_CFG)
        cfg[awaddr[7:4]] <= wdata[11:0];
    end
  end

  always @(negedge ref_clk_i)
  begin
    if (!reset_i)
    begin
      `CMP(stop, e_stop)
      `CMP(rec, e_rec)
      `CMP(halt, e_brk || hlt_q)
      `CMP(usr, usr_q)
      `CMP(irq, (st & ien) != 3'h0)
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge ref_clk_i);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid)
      begin
        done = 1;
        `CMP(bresp, er)
      end
    end
    if (!done)
    begin
      mismatches++;
      finish_test();
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    bit done;
    done = 0;
    araddr <= a;
    arvalid <= 1;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge ref_clk_i);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid)
      begin
        done = 1;
        `CMP(rdata, e)
        `CMP(rresp, er)
      end
    end
    if (!done)
    begin
      mismatches++;
      finish_test();
    end
  endtask : rd

  initial
  begin
    int g;
    logic [11:0] gb;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 0;
    @(posedge ref_clk_i);
    rd(IPBC_OFF_CTRL, 32'h0, IPBC_RESP_OKAY);
    rd(IPBC_OFF_STATE, 32'h0, IPBC_RESP_OKAY);
    rd(12'h158, 32'h0, IPBC_RESP_OKAY);
    rd(12'h10c, 32'h0, IPBC_RESP_SLVERR);
    wr(12'h01c, 32'h5, IPBC_RESP_SLVERR);
    for (int k = 0; k < 48; k++)
    begin
      g = k % IPBC_NGRP;
      gb = 12'h100 + 12'(g * 16);
      // First passes may leave advanced mode off
      wr(IPBC_OFF_CTRL, (rnd() & 32'hf) | 32'(k > 2), IPBC_RESP_OKAY);
      wr(gb, 32'(g * 64 + 4), IPBC_RESP_OKAY);
      wr(gb + 12'h4, 32'(g * 64 + 20), IPBC_RESP_OKAY);
      wr(gb + 12'h8, rnd() & 32'hfff, IPBC_RESP_OKAY);
      wr(IPBC_OFF_IRQ_EN, rnd() & 32'h7, IPBC_RESP_OKAY);
      run <= 1;
      repeat (40)
      begin
        @(posedge ref_clk_i);
        jump <= rnd() % 3 != 0;
        target <= 24'(((rnd() & 1) ? g : rnd() % 16) * 64 + rnd() % 24);
        level <= 4'(rnd());
        ce <= rnd() % 5 != 0;
      end
      run <= 0;
      jump <= 0;
      ce <= 1;
      repeat (3) @(posedge ref_clk_i);
      rd(IPBC_OFF_STATUS, {29'h0, st}, IPBC_RESP_OKAY);
      rd(IPBC_OFF_STATE, {30'h0, hlt_q, usr_q}, IPBC_RESP_OKAY);
      rd(gb + 12'h8, {20'h0, cfg[g]}, IPBC_RESP_OKAY);
      rd(gb + 12'h4, {8'h0, sa[g]}, IPBC_RESP_OKAY);
      wr(IPBC_OFF_IRQ_CLR, rnd() & 32'h7, IPBC_RESP_OKAY);
      // Always resume so the next pass runs
      wr(IPBC_OFF_CMD, (rnd() & 32'h2) | 32'h1, IPBC_RESP_OKAY);
    end
    finish_test();
  end
endmodule : test_ipbc_top
